// ==== dv/apc_codec_model.sv ====
`default_nettype none
module apc_codec_model (
    input wire logic hf_run, // run the sample clocks
    input wire logic fs_lvl, // frame sync level sent
    input wire apc_pkg::apc_pins_t pin_o, // device drive values
    input wire apc_pkg::apc_pins_t pin_oe, // device drive enables
    output apc_pkg::apc_pins_t pin_i // resolved pad levels
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hf = 1'b0;
    // stands low while hf_run is clear rather than floating
    always begin
        #100;
        hf = hf_run ? ~hf : 1'b0;
    end
    always_comb begin
        pin_i.rx_hf_clock = pin_oe.rx_hf_clock ? pin_o.rx_hf_clock : hf;
        pin_i.tx_hf_clock = pin_oe.tx_hf_clock ? pin_o.tx_hf_clock : hf;
        pin_i.rx_frame_sync = pin_oe.rx_frame_sync ? pin_o.rx_frame_sync : fs_lvl;
        pin_i.tx_frame_sync = pin_oe.tx_frame_sync ? pin_o.tx_frame_sync : fs_lvl;
    end
endmodule
`default_nettype wire

// ==== dv/tb_audio_port_clock_sync_pins.sv ====
`default_nettype none
module tb_audio_port_clock_sync_pins;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, rx_fs_gen = 1'b0, tx_fs_gen = 1'b0, slot_strobe = 1'b0, tx_buf_en = 1'b0;
    logic hf_run = 1'b0, fs_lvl = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic rx_clk_tick, tx_clk_tick, rx_fs_use, tx_fs_use;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    apc_pkg::apc_pins_t pin_i, pin_o, pin_oe;
    logic [31:0] m [6] = '{default: 32'h0};
    int bad_count = 0, n_compared = 0, e0, e1, t0, t1;

    apc_pin_func dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pin_i, .pin_o, .pin_oe, .rx_fs_gen, .tx_fs_gen, .slot_strobe, .tx_buf_en,
        .rx_clk_tick, .tx_clk_tick, .rx_fs_use, .tx_fs_use);
    apc_codec_model codec_u (.hf_run, .fs_lvl, .pin_o, .pin_oe, .pin_i);

    always #12.5 aclk = ~aclk;

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // writable bits of the modelled registers; status and port data checked apart
    function automatic logic [31:0] msk(input logic [7:0] a);
        case (a)
            8'h00, 8'h10: msk = 32'hFF;
            8'h08, 8'h0C: msk = 32'hFFFF;
            default: msk = 32'h0;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'b0;
        if (n >= 40) bad_count++;
        chk(s_axi_bresp, a > 8'h14 ? apc_pkg::RESP_SLVERR : apc_pkg::RESP_OKAY);
        if (msk(a) != 0) m[a[4:2]] = x & msk(a);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        s_axi_rready <= 1'b0;
        r = s_axi_rdata;
        if (n >= 40) bad_count++;
        chk(s_axi_rresp, a > 8'h14 ? apc_pkg::RESP_SLVERR : apc_pkg::RESP_OKAY);
        if (msk(a) != 0) chk(r & msk(a), m[a[4:2]]);
    endtask

    task automatic watch(input int cyc);
        apc_pkg::apc_pins_t p;
        p = pin_o;
        e0 = 0; e1 = 0; t0 = 0; t1 = 0;
        repeat (cyc) begin
            @(posedge aclk);
            e0 += int'(pin_o.rx_hf_clock != p.rx_hf_clock);
            e1 += int'(pin_o.tx_hf_clock != p.tx_hf_clock);
            t0 += int'(rx_clk_tick);
            t1 += int'(tx_clk_tick);
            p = pin_o;
        end
    endtask

    task automatic fs_pulse;
        repeat (3) @(posedge aclk);
        tx_fs_gen <= 1'b1;
        repeat (2) @(posedge aclk);
        tx_fs_gen <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    initial begin
        #100us;
        bad_count++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h5DEFF9CE));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        chk(pin_oe, 0);
        chk(pin_o, 0);
        chk(rx_clk_tick & tx_clk_tick, 1);
        foreach (m[i]) rd(8'(i * 4), v);
        rd(8'h14, v);
        chk(v[7:0], 0);
        rd(8'h40, v);
        $display("test reset done");
        d = $urandom;
        fs_lvl <= d[4];
        wr(8'h10, 32'h92);
        wr(8'h14, d);
        wr(8'h40, 32'hFF);
        repeat (4) @(posedge aclk);
        chk(pin_oe, 4'b1001);
        chk(pin_o, d[3:0]);
        rd(8'h14, v);
        chk(v[7:0], {1'b0, d[4], 2'b00, d[3:0]});
        $display("test port done");
        wr(8'h00, 32'h30);
        wr(8'h08, 32'h2);
        wr(8'h0C, 32'h102);
        watch(40);
        chk(pin_oe[1:0], 2'b11);
        chk(32'(e0 inside {[39:40]}), 1);
        chk(32'(e1 inside {[19:21]}), 1);
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'h0);
        hf_run <= 1'b1;
        watch(80);
        chk(32'(t0 inside {[9:11]}), 1);
        chk(32'(t1 inside {[9:11]}), 1);
        hf_run <= 1'b0;
        $display("test hf clocks done");
        wr(8'h00, 32'hF0);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            fs_lvl <= d[0];
            tx_fs_gen <= d[1];
            rx_fs_gen <= d[4];
            wr(8'h08, {31'h0, d[3]});
            wr(8'h0C, {31'h0, d[2]});
            repeat (4) @(posedge aclk);
            chk(rx_fs_use, d[3] ? d[4] : d[0]);
            chk(pin_oe.rx_frame_sync, d[3]);
            chk(pin_oe.tx_frame_sync, d[2]);
            chk(tx_fs_use, d[2] ? d[1] : d[0]);
        end
        fs_lvl <= 1'b0;
        wr(8'h00, 32'hF2);
        wr(8'h0C, 32'h1);
        tx_fs_gen <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(rx_fs_use, 1);
        tx_fs_gen <= 1'b0;
        rx_fs_gen <= 1'b1;
        wr(8'h08, 32'h1);
        wr(8'h00, 32'hF3);
        repeat (4) @(posedge aclk);
        chk(pin_oe.rx_frame_sync, 1);
        chk(pin_o.rx_frame_sync, 0);
        fs_pulse();
        chk(pin_o.rx_frame_sync, 1);
        wr(8'h08, 32'h0);
        fs_lvl <= 1'b1;
        fs_pulse();
        fs_lvl <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(8'h04, v);
        chk(v[0], 1);
        $display("test frame sync and flags done");
        wr(8'h08, 32'h1);
        wr(8'h00, 32'hFA);
        repeat (4) @(posedge aclk);
        chk(pin_o.rx_frame_sync, 1);
        slot_strobe <= 1'b1;
        @(posedge aclk);
        slot_strobe <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(pin_o.rx_frame_sync, 0);
        wr(8'h00, 32'hF6);
        repeat (4) begin
            d = $urandom;
            tx_buf_en <= d[0];
            repeat (3) @(posedge aclk);
            chk(pin_o.rx_frame_sync, d[0]);
        end
        foreach (m[i]) rd(8'(i * 4), v);
        $display("test buffer enable done");
        complete_run();
    end
endmodule
`default_nettype wire

// ==== pkg/apc_pkg.sv ====
`default_nettype none
package apc_pkg;
    // register byte offsets on the control bus
    localparam logic [7:0] COMMON_CONTROL_OFF = 8'h00;
    localparam logic [7:0] COMMON_STATUS_OFF = 8'h04;
    localparam logic [7:0] RX_CLOCK_CONTROL_OFF = 8'h08;
    localparam logic [7:0] TX_CLOCK_CONTROL_OFF = 8'h0C;
    localparam logic [7:0] PORT_DIR_OFF = 8'h10;
    localparam logic [7:0] PORT_DATA_OFF = 8'h14;

    // common_control_reg fields
    localparam int OUT_FLAG_ONE_BIT = 0;
    localparam int SYNC_MODE_SEL_BIT = 1;
    localparam int TX_BUFFER_ENABLE_SEL_BIT = 2;
    localparam int NETWORK_MODE_BIT = 3;
    localparam int AUDIO_FUNC_LSB = 4;

    // common_status_reg fields
    localparam int IN_FLAG_ONE_BIT = 0;
    localparam int PIN_LEVEL_LSB = 4;

    // rx/tx clock control fields
    localparam int FRAME_SYNC_DIR_BIT = 0;
    localparam int HF_DIR_BIT = 1;
    localparam int HF_DIV_LSB = 8;
    localparam int HF_DIV_W = 8;

    // port bit modes, two bits per pin
    localparam logic [1:0] PORT_MODE_OFF = 2'h0;
    localparam logic [1:0] PORT_MODE_IN = 2'h1;
    localparam logic [1:0] PORT_MODE_OUT = 2'h2;

    // values after reset: port function, every pin disconnected
    localparam logic [7:0] COMMON_CONTROL_RESET = 8'h00;
    localparam logic [15:0] CLOCK_CONTROL_RESET = 16'h0000;
    localparam logic [7:0] PORT_DIR_RESET = 8'h00;
    localparam logic [3:0] PORT_DATA_RESET = 4'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // bit order of every pin group: rx hf, tx hf, rx fs, tx fs
    typedef struct packed {
        logic tx_frame_sync;
        logic rx_frame_sync;
        logic tx_hf_clock;
        logic rx_hf_clock;
    } apc_pins_t;
endpackage
`default_nettype wire

// ==== rtl/apc_pin_func.sv ====
// Operation
// - receive hf clock pin as input may clock the receiver instead of core clock.
// - receive hf clock pin as output drives a divided sample clock.
// - transmit hf clock pin as input may clock the transmitter instead of core clock.
// - transmit hf clock pin as output drives a divided sample clock.
// - in port use each pin is input, output or disconnected, separately.
// - after reset every pin is a port bit and disconnected.
// - sync mode off: receive frame sync pin is receivers' frame sync.
// - sync mode on, buffer enable off: receive frame sync pin is flag one.
// - sync, buffer enable and rx frame sync direction set: pin drives buffer enable.
// - flag direction follows the receive frame sync direction bit.
// - output flag shows the out_flag_one control bit.
// - output flag changes at frame sync, or each slot in network mode.
// - input flag latched into in_flag_one at frame sync or each slot.
// - sync mode: transmit frame sync pin serves transmitters and receivers.
// - async mode: transmit frame sync pin serves transmitters only.
// - transmit frame sync pin direction follows the tx frame sync direction bit.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`default_nettype none
module apc_pin_func (
    input wire logic aclk, // core clock, 40 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte lanes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire apc_pkg::apc_pins_t pin_i, // pin levels from pads
    output apc_pkg::apc_pins_t pin_o, // pin drive values
    output apc_pkg::apc_pins_t pin_oe, // pin drive enables
    input wire logic rx_fs_gen, // receiver frame sync made inside
    input wire logic tx_fs_gen, // transmitter frame sync made inside
    input wire logic slot_strobe, // one pulse per time slot
    input wire logic tx_buf_en, // transmitter external buffer enable
    output logic rx_clk_tick, // receiver clock source tick
    output logic tx_clk_tick, // transmitter clock source tick
    output logic rx_fs_use, // frame sync the receivers follow
    output logic tx_fs_use // frame sync the transmitters follow
);
    localparam int HF_CNT_W = apc_pkg::HF_DIV_W;

    logic [7:0] ctrl_reg;
    logic [15:0] rx_clk_ctrl_reg;
    logic [15:0] tx_clk_ctrl_reg;
    logic [7:0] port_dir_reg;
    logic [3:0] port_data_reg;
    logic in_flag_reg;
    logic out_flag_reg;
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic fs_prev_reg;
    logic [1:0] hf_prev_reg;
    logic [1:0] hf_out_reg;
    logic [HF_CNT_W-1:0] hf_cnt_reg [2];
    logic [1:0] hf_tick;
    logic [3:0] audio_sel;
    logic [3:0] port_in;
    logic sync_mode;
    logic tx_buffer_enable_sel;
    logic rx_frame_sync_dir;
    logic tx_frame_sync_dir;
    logic flag_mode;
    logic flag_event;
    apc_pkg::apc_pins_t func_o;
    apc_pkg::apc_pins_t func_oe;
    logic [7:0] aw_addr_reg;
    logic aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_held_reg;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;

    assign sync_mode = ctrl_reg[apc_pkg::SYNC_MODE_SEL_BIT];
    assign tx_buffer_enable_sel = ctrl_reg[apc_pkg::TX_BUFFER_ENABLE_SEL_BIT];
    assign rx_frame_sync_dir = rx_clk_ctrl_reg[apc_pkg::FRAME_SYNC_DIR_BIT];
    assign tx_frame_sync_dir = tx_clk_ctrl_reg[apc_pkg::FRAME_SYNC_DIR_BIT];
    assign audio_sel = ctrl_reg[apc_pkg::AUDIO_FUNC_LSB +: 4];

    // pins are asynchronous to aclk: two flops before any use
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= pin_i[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
            // a disconnected or output port bit reads as zero inside
            assign port_in[gi] = sync_reg[gi] && (port_dir_reg[2*gi +: 2] == apc_pkg::PORT_MODE_IN);
        end
    endgenerate

    // hf clock pins: edge detect when input, divider when output
    logic [1:0] hf_dir;
    assign hf_dir = {tx_clk_ctrl_reg[apc_pkg::HF_DIR_BIT], rx_clk_ctrl_reg[apc_pkg::HF_DIR_BIT]};
    generate
        for (gi = 0; gi < 2; gi++) begin : g_hf
            logic [HF_CNT_W-1:0] div;
            assign div = (gi == 0) ? rx_clk_ctrl_reg[apc_pkg::HF_DIV_LSB +: HF_CNT_W]
                                   : tx_clk_ctrl_reg[apc_pkg::HF_DIV_LSB +: HF_CNT_W];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    hf_prev_reg[gi] <= 1'b0;
                end else begin
                    hf_prev_reg[gi] <= sync_reg[gi];
                end
            end
            // output clock period is 2*(div+1) core cycles
            always_ff @(posedge aclk) begin
                if (!aresetn || !audio_sel[gi] || !hf_dir[gi]) begin
                    hf_cnt_reg[gi] <= '0;
                    hf_out_reg[gi] <= 1'b0;
                end else if (hf_cnt_reg[gi] >= div) begin
                    hf_cnt_reg[gi] <= '0;
                    hf_out_reg[gi] <= !hf_out_reg[gi];
                end else begin
                    hf_cnt_reg[gi] <= hf_cnt_reg[gi] + 1'b1;
                end
            end
            // input mode takes the pin rising edge, else every core cycle
            assign hf_tick[gi] = (audio_sel[gi] && !hf_dir[gi]) ? (sync_reg[gi] && !hf_prev_reg[gi]) : 1'b1;
        end
    endgenerate
    assign rx_clk_tick = hf_tick[0];
    assign tx_clk_tick = hf_tick[1];

    // frame sync routing
    always_comb begin
        tx_fs_use = tx_frame_sync_dir ? tx_fs_gen : (audio_sel[3] && sync_reg[3]);
        if (sync_mode) begin
            rx_fs_use = tx_fs_use;
        end else begin
            rx_fs_use = rx_frame_sync_dir ? rx_fs_gen : (audio_sel[2] && sync_reg[2]);
        end
    end

    assign flag_mode = sync_mode && !tx_buffer_enable_sel;
    // flags move at the frame sync edge, or each slot in network mode
    assign flag_event = ctrl_reg[apc_pkg::NETWORK_MODE_BIT] ? slot_strobe : (tx_fs_use && !fs_prev_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fs_prev_reg <= 1'b0;
        end else begin
            fs_prev_reg <= tx_fs_use;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_flag_reg <= 1'b0;
        end else if (flag_event) begin
            out_flag_reg <= ctrl_reg[apc_pkg::OUT_FLAG_ONE_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_flag_reg <= 1'b0;
        end else if (audio_sel[2] && flag_mode && !rx_frame_sync_dir && flag_event) begin
            in_flag_reg <= sync_reg[2];
        end
    end

    // audio function drive for each pin
    always_comb begin
        func_o.rx_hf_clock = hf_out_reg[0];
        func_oe.rx_hf_clock = hf_dir[0];
        func_o.tx_hf_clock = hf_out_reg[1];
        func_oe.tx_hf_clock = hf_dir[1];
        func_o.tx_frame_sync = tx_fs_gen;
        func_oe.tx_frame_sync = tx_frame_sync_dir;
        if (!sync_mode) begin
            func_o.rx_frame_sync = rx_fs_gen;
            func_oe.rx_frame_sync = rx_frame_sync_dir;
        end else if (!tx_buffer_enable_sel) begin
            func_o.rx_frame_sync = out_flag_reg;
            func_oe.rx_frame_sync = rx_frame_sync_dir;
        end else begin
            // no function defined with rx_frame_sync_dir clear: pin stays undriven
            func_o.rx_frame_sync = tx_buf_en;
            func_oe.rx_frame_sync = rx_frame_sync_dir;
        end
    end

    // registered pad drive; port mode follows the per-pin mode field
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pad
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_o[gi] <= 1'b0;
                    pin_oe[gi] <= 1'b0;
                end else if (audio_sel[gi]) begin
                    pin_o[gi] <= func_o[gi];
                    pin_oe[gi] <= func_oe[gi];
                end else begin
                    pin_o[gi] <= port_data_reg[gi];
                    pin_oe[gi] <= (port_dir_reg[2*gi +: 2] == apc_pkg::PORT_MODE_OUT);
                end
            end
        end
    endgenerate

    // AXI4-Lite slave: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (aw_held_reg && w_held_reg) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (aw_held_reg && w_held_reg) begin
            w_held_reg <= 1'b0;
        end
    end

    always_comb begin
        case (aw_addr_reg[7:2])
            apc_pkg::COMMON_CONTROL_OFF[7:2],
            apc_pkg::COMMON_STATUS_OFF[7:2],
            apc_pkg::RX_CLOCK_CONTROL_OFF[7:2],
            apc_pkg::TX_CLOCK_CONTROL_OFF[7:2],
            apc_pkg::PORT_DIR_OFF[7:2],
            apc_pkg::PORT_DATA_OFF[7:2]: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= apc_pkg::RESP_OKAY;
        end else if (aw_held_reg && w_held_reg) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register writes; status register is read only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= apc_pkg::COMMON_CONTROL_RESET;
            rx_clk_ctrl_reg <= apc_pkg::CLOCK_CONTROL_RESET;
            tx_clk_ctrl_reg <= apc_pkg::CLOCK_CONTROL_RESET;
            port_dir_reg <= apc_pkg::PORT_DIR_RESET;
            port_data_reg <= apc_pkg::PORT_DATA_RESET;
        end else if (aw_held_reg && w_held_reg) begin
            case (aw_addr_reg)
                apc_pkg::COMMON_CONTROL_OFF: begin
                    if (w_strb_reg[0]) ctrl_reg <= w_data_reg[7:0];
                end
                apc_pkg::RX_CLOCK_CONTROL_OFF: begin
                    if (w_strb_reg[0]) rx_clk_ctrl_reg[7:0] <= w_data_reg[7:0];
                    if (w_strb_reg[1]) rx_clk_ctrl_reg[15:8] <= w_data_reg[15:8];
                end
                apc_pkg::TX_CLOCK_CONTROL_OFF: begin
                    if (w_strb_reg[0]) tx_clk_ctrl_reg[7:0] <= w_data_reg[7:0];
                    if (w_strb_reg[1]) tx_clk_ctrl_reg[15:8] <= w_data_reg[15:8];
                end
                apc_pkg::PORT_DIR_OFF: begin
                    if (w_strb_reg[0]) port_dir_reg <= w_data_reg[7:0];
                end
                apc_pkg::PORT_DATA_OFF: begin
                    if (w_strb_reg[0]) port_data_reg <= w_data_reg[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            apc_pkg::COMMON_CONTROL_OFF: rd_word[7:0] = ctrl_reg;
            apc_pkg::COMMON_STATUS_OFF: begin
                rd_word[apc_pkg::IN_FLAG_ONE_BIT] = in_flag_reg;
                rd_word[apc_pkg::PIN_LEVEL_LSB +: 4] = sync_reg;
            end
            apc_pkg::RX_CLOCK_CONTROL_OFF: rd_word[15:0] = rx_clk_ctrl_reg;
            apc_pkg::TX_CLOCK_CONTROL_OFF: rd_word[15:0] = tx_clk_ctrl_reg;
            apc_pkg::PORT_DIR_OFF: rd_word[7:0] = port_dir_reg;
            apc_pkg::PORT_DATA_OFF: rd_word[7:0] = {port_in, port_data_reg};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= apc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    a_reset_disconnect: assert property (@(posedge aclk) !aresetn |=> pin_oe == 4'h0)
        else $error("pins driven after reset");
    a_port_output: assert property (@(posedge aclk) disable iff (!aresetn)
        !audio_sel[0] && port_dir_reg[1:0] == apc_pkg::PORT_MODE_OUT |=> pin_oe[0] && pin_o[0] == $past(port_data_reg[0]))
        else $error("port bit not driven as output");
    a_port_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !audio_sel[2] && port_dir_reg[5:4] != apc_pkg::PORT_MODE_OUT |=> !pin_oe[2])
        else $error("port bit driven while not output");
    a_hf_in_tick: assert property (@(posedge aclk) disable iff (!aresetn)
        audio_sel[0] && !hf_dir[0] && !sync_reg[0] ##1 sync_reg[0] |-> rx_clk_tick ##1 !rx_clk_tick)
        else $error("receive clock tick not on pin edge");
    a_hf_core_tick: assert property (@(posedge aclk) disable iff (!aresetn)
        !(audio_sel[1] && !hf_dir[1]) |-> tx_clk_tick)
        else $error("transmit tick missing on core clock");
    a_hf_out_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        audio_sel[0] && hf_dir[0] && $stable(rx_clk_ctrl_reg) && rx_clk_ctrl_reg[15:8] == 8'h00
        ##1 audio_sel[0] && hf_dir[0] && $stable(rx_clk_ctrl_reg) |=> hf_out_reg[0] != $past(hf_out_reg[0]))
        else $error("hf output clock does not divide");
    a_hf_out_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        audio_sel[1] && hf_dir[1] |=> pin_oe[1] && pin_o[1] == $past(hf_out_reg[1]))
        else $error("transmit hf clock not driven");
    a_buffer_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        audio_sel[2] && sync_mode && tx_buffer_enable_sel && rx_frame_sync_dir |=> pin_oe[2] && pin_o[2] == $past(tx_buf_en))
        else $error("buffer enable not on receive frame sync pin");
    a_flag_dir: assert property (@(posedge aclk) disable iff (!aresetn)
        audio_sel[2] && flag_mode |=> pin_oe[2] == $past(rx_frame_sync_dir))
        else $error("flag direction wrong");
    a_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !flag_event |=> $stable(out_flag_reg))
        else $error("output flag moved between syncs");
    a_flag_value: assert property (@(posedge aclk) disable iff (!aresetn)
        flag_event ##1 audio_sel[2] && flag_mode && rx_frame_sync_dir |=> pin_o[2] == $past(ctrl_reg[0], 2))
        else $error("output flag value wrong");
    a_in_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        audio_sel[2] && flag_mode && !rx_frame_sync_dir && flag_event |=> in_flag_reg == $past(sync_reg[2]))
        else $error("input flag not latched");
    a_rx_fs_sync: assert property (@(posedge aclk) disable iff (!aresetn)
        sync_mode |-> rx_fs_use == tx_fs_use)
        else $error("receivers not on transmit frame sync");
    a_rx_fs_async: assert property (@(posedge aclk) disable iff (!aresetn)
        !sync_mode && audio_sel[2] && !rx_frame_sync_dir |-> rx_fs_use == sync_reg[2])
        else $error("receive frame sync input lost");
    a_tx_fs_dir: assert property (@(posedge aclk) disable iff (!aresetn)
        audio_sel[3] |=> pin_oe[3] == $past(tx_frame_sync_dir) && pin_o[3] == $past(tx_fs_gen))
        else $error("transmit frame sync direction wrong");
    a_tx_fs_own: assert property (@(posedge aclk) disable iff (!aresetn)
        !sync_mode && !tx_frame_sync_dir && audio_sel[3] |-> tx_fs_use == sync_reg[3])
        else $error("transmit frame sync input lost");
endmodule
`default_nettype wire
